// *** bench/sor_link_partner.sv ***
`timescale 1ns/1ps
module sor_link_partner import sor_pkg::*; #(
   parameter int FB = 256
) (
   output logic bclk,
   output logic fsync,
   input wire logic pri_pin,
   input wire logic sec_pin
);
   logic cap_p [0:FB-1];
   logic cap_s [0:FB-1];
   initial begin
      bclk = 1'b0;
      fsync = 1'b0;
   end
   // Bit clock stands still between frames; one lead-in pulse shows the idle sync level
   task automatic run_frame(input logic [1:0] fmt);
      logic lvl;
      lvl = (fmt == SOR_FMT_I2S) ? 1'b0 : 1'b1;
      fsync = ~lvl;
      #40 bclk = 1'b1;
      #40 bclk = 1'b0;
      fsync = lvl;
      #40;
      for (int r = 0; r <= FB; r++) begin
         bclk = 1'b1;
         if (r > 0) begin
            cap_p[r-1] = pri_pin;
            cap_s[r-1] = sec_pin;
         end
         #40 bclk = 1'b0;
         if (r == 0 && fmt == SOR_FMT_TDM) fsync = 1'b0;
         if (r == FB/2 - 1 && fmt != SOR_FMT_TDM) fsync = ~lvl;
         #40;
      end
   endtask
endmodule // sor_link_partner

// *** bench/sor_top_bench.sv ***
`timescale 1ns/1ps
module sor_top_bench import sor_pkg::*; ;
   logic clk, rst_n, bclk, fsync, unused_cycle_fill, reg_wr, reg_rd, sample_valid, sample_ready;
   logic primary_data_out, primary_data_oe, secondary_data_out, secondary_data_oe;
   logic [1:0] audio_format;
   logic [4:0] slot_origin_delay;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [31:0] sample_data;
   int miscompares, num_checks;
   wire pri_pin = primary_data_oe ? primary_data_out : 1'bz;
   wire sec_pin = secondary_data_oe ? secondary_data_out : 1'bz;
   sor_top i_sor_top (.clk, .rst_n, .bclk, .fsync, .audio_format, .unused_cycle_fill,
      .slot_origin_delay, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sample_valid,
      .sample_ready, .sample_data, .primary_data_out, .primary_data_oe, .secondary_data_out,
      .secondary_data_oe);
   sor_link_partner i_sor_link_partner (.bclk, .fsync, .pri_pin, .sec_pin);
   always #2.5 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] word(input int i);
      return 32'h8000_0001 ^ (32'(i) * 32'h1357_9bdf);
   endfunction
   function automatic logic [31:0] cap_word(input bit sec, input int pos);
      logic [31:0] w;
      for (int i = 0; i < 32; i++) begin
         w[31-i] = sec ? i_sor_link_partner.cap_s[pos+i] : i_sor_link_partner.cap_p[pos+i];
      end
      return w;
   endfunction
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      check({24'h0, reg_rdata}, {24'h0, exp});
   endtask
   // Sets link inputs and both registers, then lets the partner clock one frame
   task automatic frame(input logic [1:0] f, input logic fl, input logic [4:0] d,
                        input logic [7:0] sel, input logic [7:0] cfg);
      @(negedge clk);
      audio_format = f;
      unused_cycle_fill = fl;
      slot_origin_delay = d;
      reg_write(SOR_PIN_SEL_OFS, sel);
      reg_write(SOR_CH1_CFG_OFS, cfg);
      i_sor_link_partner.run_frame(f);
   endtask
   task automatic t_regs;
      check_reg(SOR_PIN_SEL_OFS, 8'h00);
      check_reg(SOR_CH1_CFG_OFS, 8'h20);
      reg_write(SOR_PIN_SEL_OFS, 8'ha5);
      check_reg(SOR_PIN_SEL_OFS, 8'ha5);
      // Reserved bits written high on purpose to prove they stay fixed
      reg_write(SOR_CH1_CFG_OFS, 8'hff);
      check_reg(SOR_CH1_CFG_OFS, 8'h3f);
      // Read in the cycle right after the write must return the new value
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = SOR_PIN_SEL_OFS;
      reg_wdata = 8'h5a;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      check({24'h0, reg_rdata}, 32'h0000_005a);
      reg_write(8'h1c, 8'hff);
      check_reg(8'h1c, 8'h00);
      check_reg(SOR_PIN_SEL_OFS, 8'h5a);
      $display("register test done");
   endtask
   task automatic t_fifo;
      int n;
      n = 0;
      for (int i = 0; i < 24; i++) begin
         @(negedge clk);
         sample_valid = sample_ready;
         sample_data = word(n);
         if (sample_ready === 1'b1) n++;
      end
      @(negedge clk);
      sample_valid = 1'b0;
      check(32'(n), 32'd16);
      check({31'h0, sample_ready}, 32'h0);
      $display("buffer test done");
   endtask
   task automatic t_tdm;
      frame(SOR_FMT_TDM, 1'b0, 5'h00, 8'h00, 8'h22);
      check(cap_word(0, 64), word(0));
      check(cap_word(1, 64), 32'hzzzz_zzzz);
      check({30'h0, i_sor_link_partner.cap_p[0], i_sor_link_partner.cap_p[96]}, 32'h0);
      $display("tdm test done");
   endtask
   task automatic t_lj;
      frame(SOR_FMT_LJ, 1'b1, 5'h03, 8'h01, 8'h30);
      check(cap_word(1, 131), word(1));
      check(cap_word(0, 131), 32'hzzzz_zzzz);
      check({30'h0, i_sor_link_partner.cap_s[130], i_sor_link_partner.cap_p[0]},
            {30'h0, 2'bzz});
      $display("lj test done");
   endtask
   task automatic t_i2s;
      frame(SOR_FMT_I2S, 1'b0, 5'h00, 8'h00, 8'h21);
      check(cap_word(0, 33), word(2));
      check(cap_word(1, 33), 32'hzzzz_zzzz);
      $display("i2s test done");
   endtask
   task automatic t_off;
      frame(SOR_FMT_TDM, 1'b1, 5'h00, 8'h00, 8'h02);
      check(cap_word(0, 64), 32'hzzzz_zzzz);
      check(cap_word(1, 64), 32'hzzzz_zzzz);
      $display("disable test done");
   endtask
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      audio_format = SOR_FMT_TDM;
      unused_cycle_fill = 1'b0;
      slot_origin_delay = 5'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      sample_valid = 1'b0;
      sample_data = 32'h0;
      miscompares = 0;
      num_checks = 0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      t_regs();
      t_fifo();
      t_tdm();
      t_lj();
      t_i2s();
      t_off();
      end_of_test();
   end
endmodule // sor_top_bench

// *** include/sor_pkg.sv ***
package sor_pkg;
   localparam logic [7:0] SOR_PIN_SEL_OFS = 8'h1d;
   localparam logic [7:0] SOR_CH1_CFG_OFS = 8'h1e;
   localparam logic [7:0] SOR_PIN_SEL_RST = 8'h00;
   localparam logic [7:0] SOR_CH1_CFG_RST = 8'h20;
   localparam int SOR_CH1_EN_BIT = 5;
   localparam int SOR_SLOT_MSB = 4;
   localparam int SOR_RSVD_MSB = 7;
   localparam int SOR_RSVD_LSB = 6;
   localparam int SOR_SAMPLE_W = 32;
   localparam int SOR_FIFO_DEPTH = 16;
   localparam int SOR_CNT_W = 11;
   localparam logic [SOR_CNT_W-1:0] SOR_CNT_MAX = 11'h7ff;
   localparam logic [4:0] SOR_LAST_BIT = 5'h1f;
   localparam logic [1:0] SOR_FMT_TDM = 2'h0;
   localparam logic [1:0] SOR_FMT_I2S = 2'h1;
   localparam logic [1:0] SOR_FMT_LJ = 2'h2;
endpackage

// *** rtl/sor_fifo.sv ***
`timescale 1ns/1ps
module sor_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic ready_reg, ready_next;
   logic push, pop;

   assign push = in_valid && ready_reg;
   assign pop = out_ready && (cnt_reg != '0);
   assign in_ready = ready_reg;
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_reg];

   always_comb begin
      mem_next = mem_reg;
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         mem_next[wr_reg] = in_data;
         wr_next = wr_reg + 1'b1;
      end
      if (pop) begin
         rd_next = rd_reg + 1'b1;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
      // Ready is a flop so the top output comes straight from a register
      ready_next = (cnt_next != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         mem_reg <= mem_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         ready_reg <= ready_next;
      end
   end
endmodule // sor_fifo

// *** rtl/sor_top.sv ***
`timescale 1ns/1ps
// Operation
// - Pin-select bit n-1 sends channel n to primary pin (0) or secondary (1).
// - Pin-select register resets to zero, all channels on the primary pin.
// - Channel 1 enable low leaves its slot to the unused-cycle fill; high sends microphone samples.
// - Five-bit slot index picks TDM slot 0 to 31 directly.
// - In I2S/LJ, index 0-15 is left slot, 16-31 right slot 0-15.
// - Channel 1 configuration resets to 0x20: enabled, slot 0.
// - Unused bit-clock cycles drive low when fill is 0, high impedance when 1.
// - Slot 0 MSB is delayed by the origin delay of 0 to 31 bit clocks.
module sor_top import sor_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bclk,
   input wire logic fsync,
   input wire logic [1:0] audio_format,
   input wire logic unused_cycle_fill,
   input wire logic [4:0] slot_origin_delay,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [SOR_SAMPLE_W-1:0] sample_data,
   output logic primary_data_out,
   output logic primary_data_oe,
   output logic secondary_data_out,
   output logic secondary_data_oe
);
   function automatic logic [7:0] reg_mux(input logic [7:0] addr, input logic [7:0] sel,
                                          input logic [7:0] cfg);
      case (addr)
         SOR_PIN_SEL_OFS: reg_mux = sel;
         SOR_CH1_CFG_OFS: reg_mux = cfg;
         default: reg_mux = 8'h00;
      endcase
   endfunction

   logic bclk_s1_reg, bclk_s2_reg, bclk_s3_reg, fs_s1_reg, fs_s2_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bclk_s1_reg <= 1'b0;
         bclk_s2_reg <= 1'b0;
         bclk_s3_reg <= 1'b0;
         fs_s1_reg <= 1'b0;
         fs_s2_reg <= 1'b0;
      end else begin
         bclk_s1_reg <= bclk;
         bclk_s2_reg <= bclk_s1_reg;
         // Third stage only feeds the edge detector, never the first stage
         bclk_s3_reg <= bclk_s2_reg;
         fs_s1_reg <= fsync;
         fs_s2_reg <= fs_s1_reg;
      end
   end
   logic bclk_rise, bclk_fall;
   assign bclk_rise = bclk_s2_reg && !bclk_s3_reg;
   assign bclk_fall = !bclk_s2_reg && bclk_s3_reg;

   // Register file
   logic [7:0] pin_sel_reg, pin_sel_next, ch1_cfg_reg, ch1_cfg_next, rdata_reg, rdata_next;
   always_comb begin
      pin_sel_next = pin_sel_reg;
      ch1_cfg_next = ch1_cfg_reg;
      rdata_next = rdata_reg;
      if (reg_wr && reg_addr == SOR_PIN_SEL_OFS) begin
         pin_sel_next = reg_wdata;
      end
      if (reg_wr && reg_addr == SOR_CH1_CFG_OFS) begin
         // Reserved bits stay at reset value whatever is written
         ch1_cfg_next = {SOR_CH1_CFG_RST[SOR_RSVD_MSB:SOR_RSVD_LSB],
                         reg_wdata[SOR_CH1_EN_BIT:0]};
      end
      if (reg_rd) begin
         rdata_next = reg_mux(reg_addr, pin_sel_reg, ch1_cfg_reg);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sel_reg <= SOR_PIN_SEL_RST;
         ch1_cfg_reg <= SOR_CH1_CFG_RST;
         rdata_reg <= 8'h00;
      end else begin
         pin_sel_reg <= pin_sel_next;
         ch1_cfg_reg <= ch1_cfg_next;
         rdata_reg <= rdata_next;
      end
   end
   assign reg_rdata = rdata_reg;

   // Sample buffer; drained one word per frame
   logic fifo_valid, fifo_pop;
   logic [SOR_SAMPLE_W-1:0] fifo_data;
   sor_fifo #(.WIDTH(SOR_SAMPLE_W), .DEPTH(SOR_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // Frame tracking and transmit
   logic fs_prev_reg, fs_prev_next, half_reg, half_next, synced_reg, synced_next;
   logic [SOR_CNT_W-1:0] cnt_reg, cnt_next;
   logic [SOR_SAMPLE_W-1:0] word_reg, word_next;
   logic pd_reg, pd_next, po_reg, po_next, sd_reg, sd_next, so_reg, so_next;
   logic [SOR_CNT_W-1:0] delay_c, pos_c;
   logic [4:0] bit_c, slot_idx;
   logic ch_en, sel1, pos_ok, match_c, active_c, start_c, dbit_c, is_tdm;

   assign ch_en = ch1_cfg_reg[SOR_CH1_EN_BIT];
   assign slot_idx = ch1_cfg_reg[SOR_SLOT_MSB:0];
   assign sel1 = pin_sel_reg[0];
   assign is_tdm = (audio_format == SOR_FMT_TDM);
   // I2S carries one bit clock of protocol delay ahead of the offset
   assign delay_c = SOR_CNT_W'(slot_origin_delay) +
                    SOR_CNT_W'(audio_format == SOR_FMT_I2S);
   assign pos_ok = (cnt_reg >= delay_c);
   assign pos_c = cnt_reg - delay_c;
   assign bit_c = pos_c[4:0];
   // TDM uses the whole index; I2S/LJ split it into half and slot
   assign match_c = is_tdm ? (!pos_c[10] && pos_c[9:5] == slot_idx)
                  : (pos_c[10:9] == 2'b00 && pos_c[8:5] == slot_idx[3:0]
                     && half_reg == slot_idx[4]);
   assign active_c = ch_en && synced_reg && pos_ok && match_c;
   assign start_c = bclk_rise && (fs_s2_reg != fs_prev_reg) && (!is_tdm || fs_s2_reg);
   assign fifo_pop = bclk_fall && active_c && (bit_c == 5'h00) && fifo_valid;
   // An empty buffer sends silence rather than stalling the frame
   assign dbit_c = (bit_c == 5'h00) ? (fifo_valid && fifo_data[SOR_SAMPLE_W-1])
                                    : word_reg[SOR_LAST_BIT - bit_c];

   always_comb begin
      fs_prev_next = fs_prev_reg;
      half_next = half_reg;
      synced_next = synced_reg;
      cnt_next = cnt_reg;
      word_next = word_reg;
      pd_next = pd_reg;
      po_next = po_reg;
      sd_next = sd_reg;
      so_next = so_reg;
      if (bclk_rise) begin
         fs_prev_next = fs_s2_reg;
      end
      if (start_c) begin
         cnt_next = '0;
         synced_next = 1'b1;
         half_next = (audio_format == SOR_FMT_I2S) ? fs_s2_reg : !fs_s2_reg;
      end else if (bclk_fall) begin
         if (cnt_reg != SOR_CNT_MAX) begin
            cnt_next = cnt_reg + 1'b1;
         end
         if (active_c && bit_c == 5'h00) begin
            word_next = fifo_valid ? fifo_data : '0;
         end
         if (active_c) begin
            // Selected pin carries data, the other is released
            pd_next = sel1 ? 1'b0 : dbit_c;
            po_next = !sel1;
            sd_next = sel1 ? dbit_c : 1'b0;
            so_next = sel1;
         end else begin
            pd_next = 1'b0;
            po_next = !unused_cycle_fill;
            sd_next = 1'b0;
            so_next = !unused_cycle_fill;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fs_prev_reg <= 1'b0;
         half_reg <= 1'b0;
         synced_reg <= 1'b0;
         cnt_reg <= '0;
         word_reg <= '0;
         pd_reg <= 1'b0;
         po_reg <= 1'b0;
         sd_reg <= 1'b0;
         so_reg <= 1'b0;
      end else begin
         fs_prev_reg <= fs_prev_next;
         half_reg <= half_next;
         synced_reg <= synced_next;
         cnt_reg <= cnt_next;
         word_reg <= word_next;
         pd_reg <= pd_next;
         po_reg <= po_next;
         sd_reg <= sd_next;
         so_reg <= so_next;
      end
   end
   assign primary_data_out = pd_reg;
   assign primary_data_oe = po_reg;
   assign secondary_data_out = sd_reg;
   assign secondary_data_oe = so_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence tx_slot_s;
      bclk_fall && !start_c && active_c;
   endsequence
   sequence tx_idle_s;
      bclk_fall && !start_c && !active_c;
   endsequence

   a_route_primary: assert property (tx_slot_s and !sel1 |=> po_reg && !so_reg)
      else $error("channel 1 not on primary pin");
   a_route_second: assert property (tx_slot_s and sel1 |=> so_reg && !po_reg)
      else $error("channel 1 not on secondary pin");
   a_sel_readback: assert property ((reg_wr && reg_addr == SOR_PIN_SEL_OFS) ##1
      (reg_rd && !reg_wr && reg_addr == SOR_PIN_SEL_OFS) |=> rdata_reg == $past(reg_wdata, 2))
      else $error("pin select readback wrong");
   a_disabled_quiet: assert property (bclk_fall && !start_c && !ch_en && unused_cycle_fill
      |=> !po_reg && !so_reg)
      else $error("disabled channel drives a pin");
   a_tdm_slot: assert property (bclk_fall && !start_c && is_tdm && ch_en && synced_reg
      && pos_ok && pos_c[10:5] == {1'b0, slot_idx} |=> po_reg != so_reg)
      else $error("tdm slot not transmitted");
   a_half_select: assert property (bclk_fall && !start_c && !is_tdm && unused_cycle_fill
      && half_reg != slot_idx[4] |=> !po_reg && !so_reg)
      else $error("wrong half transmitted");
   a_rsvd_zero: assert property (reg_rd && reg_addr == SOR_CH1_CFG_OFS
      |=> rdata_reg[SOR_RSVD_MSB:SOR_RSVD_LSB] == 2'b00)
      else $error("reserved bits not zero");
   a_fill_low: assert property (tx_idle_s and !unused_cycle_fill
      |=> po_reg && !pd_reg && so_reg && !sd_reg)
      else $error("unused cycle not driven low");
   a_origin_delay: assert property (bclk_fall && !start_c && cnt_reg < delay_c
      && unused_cycle_fill |=> !po_reg && !so_reg)
      else $error("data before delayed origin");
   a_msb_first: assert property (tx_slot_s and bit_c == 5'h00 and fifo_valid and !sel1
      |=> pd_reg == $past(fifo_data[SOR_SAMPLE_W-1]))
      else $error("msb not sent first");
endmodule // sor_top
